// ### hw/dmr_master.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - missing or faulty reply is resent, at most retry-limit times.
// - corrupted reply triggers an immediate resend, no extra wait.
// - reply is awaited for at most the slot time in bit times.
// - slot time resets to 1000 bit times, retry limit to 4.
// - a failed slave gets a nonzero link state code.
// - reply from locally dropped link: no resend, flag, drop from poll list.
// - per-slave policy: leave at once or hold until slave watchdog expires.
// - leave policy keeps slave out until seven setup telegrams reconnect it.
// - hold policy polls again next cycle without further repeats.
// - on no reply inputs are zeroed or kept per slave policy.
// - on faulty reply inputs are always zeroed.
// - per-slave choice: automatic reconnect or only on host command.
// - per-slave choice: link loss does nothing or stops the master.
// - cycle tally increments at the end of every bus cycle.
// - measured cycle time saturates at the 100 ms worst case.
// - task silence past its watchdog clears outputs, signals fail-safe or keeps outputs.
// - only diagnostic and setup telegrams until the task transferred once.
// - number of slaves without data exchange last cycle is reported.
// - cycle time in 4/25 us, updated only when no slave failed.
// - counters for good telegrams, primary-master telegrams, timeouts.
module dmr_master (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // telegram link
    output logic tel_req_o,
    output logic [2:0] tel_addr_o,
    output logic [1:0] tel_kind_o,
    input wire logic rsp_ok_i,
    input wire logic rsp_bad_i,
    input wire logic rsp_gone_i,
    input wire logic [15:0] rsp_data_i,
    input wire logic prim_ok_i,
    // control task
    input wire logic task_xfer_i,
    output logic out_zero_o,
    output logic out_failsafe_o,
    output logic [15:0] cycle_tally_o
);

    localparam int N = dmr_pkg::N_SLV;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    dmr_pkg::dmr_state_e st;
    logic [31:0] ctrl;
    logic [31:0] busp;
    logic [15:0] twd_lim;
    logic [15:0] scfg [N];
    logic [3:0] code [N];
    logic [15:0] img [N];
    logic [7:0] wdc [N];
    logic [2:0] setup_n [N];
    logic [N-1:0] conn;
    logic [N-1:0] grace;
    logic [N-1:0] rst_req;
    logic [2:0] cur;
    logic [3:0] retry;
    logic [1:0] kind;
    logic [15:0] slot_cnt;
    logic [7:0] bit_div;
    logic dx_done;
    logic [7:0] failed;
    logic [7:0] failed_tally;
    localparam int CT_WL = dmr_pkg::CT_W;
    logic [CT_WL-1:0] ct_cnt;
    logic [CT_WL-1:0] cyc_time;
    logic [4:0] ct_div;
    logic [6:0] us_div;
    logic [15:0] twd_cnt;
    logic started;
    logic stopped;
    logic pend;
    logic [31:0] diag [3];
    wire task_lost = started & (twd_cnt >= twd_lim);

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr = req & wb_we_i;
    wire [31:0] wm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [2:0] ridx = wb_adr_i[4:2];
    wire pg_cfg = wb_adr_i[7:5] == dmr_pkg::PAGE_SCFG;
    wire pg_st = wb_adr_i[7:5] == dmr_pkg::PAGE_SSTAT;
    wire wr_ctrl = wr & (wb_adr_i == dmr_pkg::OFF_CTRL);
    wire wr_busp = wr & (wb_adr_i == dmr_pkg::OFF_BUSP);
    wire wr_twd = wr & (wb_adr_i == dmr_pkg::OFF_TWD);
    wire wr_rst = wr & (wb_adr_i == dmr_pkg::OFF_RESTART);
    wire wr_cfg = wr & pg_cfg;
    wire [31:0] ctrl_w = (ctrl & ~wm) | (wb_dat_i & wm);
    wire [31:0] busp_w = (busp & ~wm) | (wb_dat_i & wm);
    wire [15:0] cfg_w = (scfg[ridx] & ~wm[15:0]) | (wb_dat_i[15:0] & wm[15:0]);
    wire resume = wr_ctrl & wb_dat_i[dmr_pkg::CT_RESUME] & wm[dmr_pkg::CT_RESUME];
    wire [N-1:0] rst_set = wr_rst ? wb_dat_i[N-1:0] & wm[N-1:0] : '0;
    wire [4:0] dsel = wb_adr_i[6:2] - dmr_pkg::OFF_DIAG2[6:2];
    wire is_diag = (wb_adr_i >= dmr_pkg::OFF_DIAG2) & (dsel < 5'h03);

    wire [31:0] rd_data =
        (wb_adr_i == dmr_pkg::OFF_CTRL) ? ctrl :
        (wb_adr_i == dmr_pkg::OFF_BUSP) ? busp :
        (wb_adr_i == dmr_pkg::OFF_TWD) ? {16'h0000, twd_lim} :
        (wb_adr_i == dmr_pkg::OFF_RESTART) ? {24'h000000, conn} :
        (wb_adr_i == dmr_pkg::OFF_STATUS) ?
            {16'h0000, failed_tally, 5'h00, started, stopped, task_lost} :
        (wb_adr_i == dmr_pkg::OFF_CYCCNT) ? {16'h0000, cycle_tally_o} :
        (wb_adr_i == dmr_pkg::OFF_CYCTIME) ? {{(32 - CT_WL){1'b0}}, cyc_time} :
        is_diag ? diag[dsel[1:0]] :
        pg_cfg ? {16'h0000, scfg[ridx]} :
        pg_st ? {img[ridx], 12'h000, code[ridx]} :
        32'h0000_0000;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rd_data : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl <= 32'h0000_0000;
            busp <= {4'h0, dmr_pkg::BITDIV_DEF, dmr_pkg::RETRY_DEF, dmr_pkg::SLOT_DEF};
            twd_lim <= dmr_pkg::TWD_DEF;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= ctrl_w & 32'h0000_000C;
            if (wr_busp)
                busp <= busp_w & 32'h0FFF_FFFF;
            if (wr_twd)
                twd_lim <= (twd_lim & ~wm[15:0]) | (wb_dat_i[15:0] & wm[15:0]);
        end
    end

    wire [15:0] slot_time = busp[15:0];
    wire [3:0] retry_lim = busp[dmr_pkg::BP_RETRY +: 4];
    wire [1:0] react = ctrl[dmr_pkg::CT_REACT +: 2];

    // ---------------------------------------------------------------
    // telegram outcome
    // ---------------------------------------------------------------
    wire in_wait = st == dmr_pkg::S_WAIT;
    wire bit_tick = bit_div == 8'h00;
    wire got_ok = in_wait & rsp_ok_i;
    wire got_gone = in_wait & ~rsp_ok_i & rsp_gone_i;
    wire got_bad = in_wait & ~rsp_ok_i & ~rsp_gone_i & rsp_bad_i;
    wire to_ev = in_wait & ~rsp_ok_i & ~rsp_gone_i & ~rsp_bad_i & (slot_cnt >= slot_time);
    wire retry_ok = (retry < retry_lim) & ~grace[cur];
    wire miss = got_bad | to_ev;
    wire resend = miss & retry_ok;
    wire fail_ev = (miss & ~retry_ok) | got_gone;
    wire [15:0] ccfg = scfg[cur];
    wire wd_over = grace[cur] & (wdc[cur] >= ccfg[dmr_pkg::CF_WD +: 8]);
    wire lose = fail_ev & conn[cur] & (got_gone | ccfg[dmr_pkg::CF_LEAVE] | wd_over);
    wire stop_ev = lose & ccfg[dmr_pkg::CF_STOP];
    wire zero_img = got_bad | got_gone | ccfg[dmr_pkg::CF_ZERO];
    wire elig = ccfg[dmr_pkg::CF_EN] & ~stopped
        & (conn[cur] | ccfg[dmr_pkg::CF_AUTO] | rst_req[cur]);
    wire [1:0] next_kind = ~conn[cur] ? dmr_pkg::K_SETUP :
        started ? dmr_pkg::K_DX : dmr_pkg::K_DIAG;
    wire go = ~started | pend;

    // ---------------------------------------------------------------
    // poll sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st <= dmr_pkg::S_IDLE;
            cur <= 3'h0;
            retry <= 4'h0;
            kind <= dmr_pkg::K_DIAG;
            slot_cnt <= 16'h0000;
            bit_div <= 8'h00;
            dx_done <= 1'b0;
            failed <= 8'h00;
            tel_req_o <= 1'b0;
            tel_addr_o <= 3'h0;
            tel_kind_o <= dmr_pkg::K_DIAG;
        end
        else
        begin
            tel_req_o <= 1'b0;
            bit_div <= bit_tick ? busp[dmr_pkg::BP_DIV +: 8] - 8'h01 : bit_div - 8'h01;
            unique case (st)
                dmr_pkg::S_IDLE:
                    if (go)
                    begin
                        st <= dmr_pkg::S_SEND;
                        cur <= 3'h0;
                        failed <= 8'h00;
                    end
                dmr_pkg::S_SEND:
                begin
                    slot_cnt <= 16'h0000;
                    if (elig)
                    begin
                        tel_req_o <= 1'b1;
                        tel_addr_o <= cur;
                        tel_kind_o <= next_kind;
                        kind <= next_kind;
                        st <= dmr_pkg::S_WAIT;
                    end
                    else
                        st <= dmr_pkg::S_NEXT;
                end
                dmr_pkg::S_WAIT:
                begin
                    if (bit_tick)
                        slot_cnt <= slot_cnt + 16'h0001;
                    if (got_ok)
                    begin
                        retry <= 4'h0;
                        dx_done <= kind == dmr_pkg::K_DX;
                        st <= dmr_pkg::S_NEXT;
                    end
                    else if (resend)
                    begin
                        retry <= retry + 4'h1;
                        st <= dmr_pkg::S_SEND;
                    end
                    else if (fail_ev)
                        st <= dmr_pkg::S_NEXT;
                end
                dmr_pkg::S_NEXT:
                begin
                    retry <= 4'h0;
                    dx_done <= 1'b0;
                    if (ccfg[dmr_pkg::CF_EN] & ~dx_done)
                        failed <= failed + 8'h01;
                    if (cur == 3'(N - 1))
                        st <= dmr_pkg::S_END;
                    else
                    begin
                        cur <= cur + 3'h1;
                        st <= dmr_pkg::S_SEND;
                    end
                end
                dmr_pkg::S_END:
                    st <= dmr_pkg::S_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // per-slave link state and input image
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stopped <= 1'b0;
            conn <= '0;
            grace <= '0;
            rst_req <= '0;
            for (int i = 0; i < N; i++)
            begin
                scfg[i] <= dmr_pkg::SCFG_DEF;
                code[i] <= dmr_pkg::C_DOWN;
                img[i] <= 16'h0000;
                wdc[i] <= 8'h00;
                setup_n[i] <= 3'h0;
            end
        end
        else
        begin
            rst_req <= rst_req | rst_set;
            if (wr_cfg)
                scfg[ridx] <= cfg_w;
            if (resume)
                stopped <= 1'b0;
            if (got_ok)
            begin
                if (kind == dmr_pkg::K_DX)
                begin
                    img[cur] <= rsp_data_i;
                    code[cur] <= dmr_pkg::C_OK;
                    grace[cur] <= 1'b0;
                    wdc[cur] <= 8'h00;
                end
                else if (kind == dmr_pkg::K_SETUP)
                begin
                    setup_n[cur] <= setup_n[cur] + 3'h1;
                    if (setup_n[cur] == 3'(dmr_pkg::SETUP_TEL - 1))
                    begin
                        conn[cur] <= 1'b1;
                        code[cur] <= dmr_pkg::C_OK;
                        rst_req[cur] <= rst_set[cur];
                        setup_n[cur] <= 3'h0;
                    end
                end
            end
            if (fail_ev)
            begin
                code[cur] <= got_gone ? dmr_pkg::C_GONE :
                    got_bad ? dmr_pkg::C_FAULT : dmr_pkg::C_NOANS;
                if (zero_img)
                    img[cur] <= 16'h0000;
                setup_n[cur] <= 3'h0;
                if (conn[cur] & ~lose)
                begin
                    grace[cur] <= 1'b1;
                    wdc[cur] <= wdc[cur] + 8'h01;
                end
                if (lose)
                begin
                    conn[cur] <= 1'b0;
                    grace[cur] <= 1'b0;
                    wdc[cur] <= 8'h00;
                end
            end
            if (stop_ev)
            begin
                stopped <= 1'b1;
                conn <= '0;
                grace <= '0;
                for (int i = 0; i < N; i++)
                    code[i] <= dmr_pkg::C_DOWN;
            end
        end
    end

    // ---------------------------------------------------------------
    // cycle tally, cycle time, task watchdog
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cycle_tally_o <= 16'h0000;
            failed_tally <= 8'h00;
            cyc_time <= '0;
            ct_cnt <= '0;
            ct_div <= 5'h00;
            us_div <= 7'h00;
            twd_cnt <= 16'h0000;
            started <= 1'b0;
            pend <= 1'b0;
            out_zero_o <= 1'b0;
            out_failsafe_o <= 1'b0;
        end
        else
        begin
            ct_div <= (ct_div == 5'(dmr_pkg::CT_CYC - 1)) ? 5'h00 : ct_div + 5'h01;
            if (ct_div == 5'(dmr_pkg::CT_CYC - 1) && ct_cnt != CT_WL'(dmr_pkg::CT_MAX))
                ct_cnt <= ct_cnt + 1'b1;
            if (task_xfer_i)
                started <= 1'b1;
            pend <= task_xfer_i | (pend & ~(st == dmr_pkg::S_IDLE));
            if (st == dmr_pkg::S_IDLE && go)
                ct_cnt <= '0;
            if (st == dmr_pkg::S_END)
            begin
                cycle_tally_o <= cycle_tally_o + 16'h0001;
                failed_tally <= failed;
                if (failed == 8'h00)
                    cyc_time <= ct_cnt;
            end
            // watchdog counts microseconds since the last task transfer
            us_div <= (us_div == 7'(dmr_pkg::US_CYC - 1)) ? 7'h00 : us_div + 7'h01;
            if (task_xfer_i)
                twd_cnt <= 16'h0000;
            else if (us_div == 7'(dmr_pkg::US_CYC - 1) && !task_lost)
                twd_cnt <= twd_cnt + 16'h0001;
            out_zero_o <= task_lost & (react == dmr_pkg::R_ZERO);
            out_failsafe_o <= task_lost & (react == dmr_pkg::R_SAFE);
        end
    end

    // ---------------------------------------------------------------
    // diagnostic counters 2, 3, 4
    // ---------------------------------------------------------------
    wire [2:0] dinc = {to_ev, prim_ok_i, got_ok};
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_diag
            dmr_tally u_tally (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .inc_i(dinc[g]),
                .cnt_o(diag[g])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    AST_RETRY_BOUND: assert property (@(posedge clk_i) disable iff (rst_i)
        retry <= retry_lim || $changed(retry_lim)) else $error("retry over limit");
    AST_BAD_RESEND: assert property (@(posedge clk_i) disable iff (rst_i)
        (got_bad & retry_ok & elig) |-> ##2 tel_req_o) else $error("no quick resend");
    AST_SLOT: assert property (@(posedge clk_i) disable iff (rst_i)
        (in_wait & (slot_cnt >= slot_time)) |=> st != dmr_pkg::S_WAIT)
        else $error("waited past slot time");
    AST_DEFAULTS: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> slot_time == 16'h03E8 && retry_lim == 4'h4)
        else $error("bad defaults");
    AST_FAIL_CODE: assert property (@(posedge clk_i) disable iff (rst_i)
        fail_ev |=> code[$past(cur)] != 4'h0) else $error("failed slave code zero");
    AST_GONE: assert property (@(posedge clk_i) disable iff (rst_i)
        got_gone |=> st == dmr_pkg::S_NEXT && !tel_req_o) else $error("resent after drop");
    AST_BAD_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        (got_bad & ~retry_ok) |=> img[$past(cur)] == 16'h0000) else $error("image kept");
    AST_CYC_TALLY: assert property (@(posedge clk_i) disable iff (rst_i)
        st == dmr_pkg::S_END |=> cycle_tally_o == $past(cycle_tally_o) + 16'h0001)
        else $error("cycle tally not advanced");
    AST_STARTUP: assert property (@(posedge clk_i) disable iff (rst_i)
        (tel_req_o & ~started) |-> tel_kind_o != dmr_pkg::K_DX) else $error("early data");
    AST_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
        (task_lost & react == dmr_pkg::R_ZERO) |=> out_zero_o) else $error("no clear");

endmodule
`default_nettype wire

// ### hw/dmr_pkg.sv
package dmr_pkg;

    // ---------------------------------------------------------------
    // sizes and timing
    // ---------------------------------------------------------------
    localparam int N_SLV = 8;
    localparam int SW = 3;
    localparam int CLK_HZ = 100_000_000;
    localparam int BAUD_HZ = 12_000_000;
    // bit time at BAUD_HZ rounds down to whole cycles
    localparam int BIT_CYC = CLK_HZ / BAUD_HZ;
    localparam int US_CYC = CLK_HZ / 1_000_000;
    // cycle-time unit is 4/25 us
    localparam int CT_NS = 160;
    localparam int CT_CYC = CT_NS * US_CYC / 1000;
    localparam int CYC_MAX_MS = 100;
    localparam int CT_MAX = CYC_MAX_MS * 1_000_000 / CT_NS;
    localparam int CT_W = $clog2(CT_MAX + 1);
    localparam int SETUP_TEL = 7;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [15:0] SLOT_DEF = 16'h03E8;
    localparam logic [3:0] RETRY_DEF = 4'h4;
    localparam logic [7:0] BITDIV_DEF = 8'(BIT_CYC);
    localparam logic [15:0] TWD_DEF = 16'h03E8;
    localparam logic [15:0] SCFG_DEF = 16'h0A0D;

    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_BUSP = 8'h04;
    localparam logic [7:0] OFF_TWD = 8'h08;
    localparam logic [7:0] OFF_RESTART = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_CYCCNT = 8'h14;
    localparam logic [7:0] OFF_CYCTIME = 8'h18;
    localparam logic [7:0] OFF_DIAG2 = 8'h1C;
    localparam logic [2:0] PAGE_SCFG = 3'h2;
    localparam logic [2:0] PAGE_SSTAT = 3'h3;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int CF_EN = 0;
    localparam int CF_LEAVE = 1;
    localparam int CF_ZERO = 2;
    localparam int CF_AUTO = 3;
    localparam int CF_STOP = 4;
    localparam int CF_WD = 8;
    localparam int BP_RETRY = 16;
    localparam int BP_DIV = 20;
    localparam int CT_RESUME = 1;
    localparam int CT_REACT = 2;

    // ---------------------------------------------------------------
    // encodings
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_SEND = 3'b001,
        S_WAIT = 3'b010,
        S_NEXT = 3'b011,
        S_END = 3'b100
    } dmr_state_e;

    localparam logic [1:0] K_DIAG = 2'h0;
    localparam logic [1:0] K_SETUP = 2'h1;
    localparam logic [1:0] K_DX = 2'h2;

    localparam logic [1:0] R_ZERO = 2'h0;
    localparam logic [1:0] R_SAFE = 2'h1;
    localparam logic [1:0] R_OPERATE = 2'h2;

    localparam logic [3:0] C_OK = 4'h0;
    localparam logic [3:0] C_NOANS = 4'h1;
    localparam logic [3:0] C_FAULT = 4'h2;
    localparam logic [3:0] C_GONE = 4'h3;
    localparam logic [3:0] C_DOWN = 4'h4;

endpackage

// ### hw/dmr_tally.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// free-running event counter, wraps silently
// ---------------------------------------------------------------
module dmr_tally (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // event
    input wire logic inc_i,
    output logic [31:0] cnt_o
);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt_o <= 32'h0000_0000;
        else if (inc_i)
            cnt_o <= cnt_o + 32'h0000_0001;
    end

endmodule
`default_nettype wire

// ### tb/dmr_master_test.sv
`timescale 1ns/1ps
`default_nettype none

module dmr_master_test;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, rd, t0, d2;
    logic wb_ack_o, tel_req_o, rsp_ok_i, rsp_bad_i, out_zero_o, out_failsafe_o;
    logic [2:0] tel_addr_o;
    logic [1:0] tel_kind_o;
    logic [15:0] rsp_data_i, cycle_tally_o;
    logic task_xfer_i = 1'b0;
    logic run = 1'b0;
    logic bad_en = 1'b0;
    logic [5:0] tick = 6'h00;
    int n_mismatch = 0;
    int num_checks = 0;
    int k, n, kb;

    always #5 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        tick <= tick + 6'h01;
        task_xfer_i <= run && tick == 6'h00;
    end

    dmr_master uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tel_req_o(tel_req_o), .tel_addr_o(tel_addr_o),
        .tel_kind_o(tel_kind_o), .rsp_ok_i(rsp_ok_i), .rsp_bad_i(rsp_bad_i), .rsp_gone_i(1'b0),
        .rsp_data_i(rsp_data_i), .prim_ok_i(1'b0), .task_xfer_i(task_xfer_i),
        .out_zero_o(out_zero_o), .out_failsafe_o(out_failsafe_o), .cycle_tally_o(cycle_tally_o));
    dmr_slave_model slv (.clk_i(clk_i), .req_i(tel_req_o), .addr_i(tel_addr_o), .bad_en_i(bad_en),
        .bad_addr_i(3'h3), .ok_o(rsp_ok_i), .bad_o(rsp_bad_i), .data_o(rsp_data_i));

    task automatic end_of_test();
        $display("mismatches %0d checks %0d", n_mismatch, num_checks);
        if (n_mismatch == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic limit(input int lim);
        if (k >= lim)
        begin
            n_mismatch++;
            $display("ERROR wait expected done seen expired");
            end_of_test();
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (wb_ack_o !== 1'b1 && k < 20);
        limit(20);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask

    task automatic wait_tel();
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (tel_req_o !== 1'b1 && k < 5000);
        limit(5000);
    endtask

    // count requests to the failing station over one bus cycle
    task automatic count_bad();
        t0 = {16'h0, cycle_tally_o};
        k = 0;
        n = 0;
        kb = 0;
        while (cycle_tally_o === t0[15:0] && k < 20000)
        begin
            @(posedge clk_i);
            k++;
            if (tel_req_o === 1'b1 && tel_addr_o === 3'h3 && n++ > 0)
                check("resend gap", 32'h2, k - kb);
            if (rsp_bad_i === 1'b1)
                kb = k;
        end
        limit(20000);
    endtask

    task automatic wait_cyc();
        count_bad();
        check("cycle tally", t0 + 32'h1, {16'h0, cycle_tally_o});
    endtask

    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, dmr_pkg::OFF_BUSP, 32'h0);
        check("bus params", 32'h0084_03E8, rd);
        wb(1'b0, 8'h30, 32'h0);
        check("unmapped", 32'h0, rd);
        n = 0;
        do
            wait_tel();
        while (tel_kind_o === dmr_pkg::K_SETUP && ++n < 100);
        check("startup kind", {30'h0, dmr_pkg::K_DIAG}, {30'h0, tel_kind_o});
        run <= 1'b1;
        n = 0;
        do
            wait_tel();
        while (tel_kind_o !== dmr_pkg::K_DX && ++n < 100);
        check("exchange kind", {30'h0, dmr_pkg::K_DX}, {30'h0, tel_kind_o});
        wait_cyc();
        wait_cyc();
        wb(1'b0, dmr_pkg::OFF_DIAG2, 32'h0);
        d2 = rd;
        wb(1'b0, 8'h6C, 32'h0);
        check("slave image", 32'hA503_0000, rd);
        wait_cyc();
        bad_en <= 1'b1;
        count_bad();
        check("tries per cycle", 32'h5, n);
        count_bad();
        check("tries next cycle", 32'h1, n);
        wb(1'b0, dmr_pkg::OFF_STATUS, 32'h0);
        check("failed tally", 32'h1, {24'h0, rd[15:8]});
        wb(1'b0, 8'h6C, 32'h0);
        check("fault image", 32'h0, {16'h0, rd[31:16]});
        check("fault code", 32'h1, {31'h0, rd[3:0] != 4'h0});
        wb(1'b0, dmr_pkg::OFF_DIAG2, 32'h0);
        check("good replies", 32'h1, {31'h0, rd > d2});
        wb(1'b1, dmr_pkg::OFF_BUSP, 32'h0080_03E8);
        count_bad();
        check("tries no retry", 32'h1, n);
        wb(1'b1, dmr_pkg::OFF_TWD, 32'h2);
        wb(1'b1, dmr_pkg::OFF_CTRL, 32'h4);
        run <= 1'b0;
        k = 0;
        while (out_failsafe_o !== 1'b1 && k < 2000)
        begin
            @(posedge clk_i);
            k++;
        end
        limit(2000);
        check("zero outputs", 32'h0, {31'h0, out_zero_o});
        end_of_test();
    end
endmodule
`default_nettype wire

// ### tb/dmr_slave_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----
// slave stations, fixed turnaround
// ----
module dmr_slave_model (
    // clock
    input wire logic clk_i,
    // telegram link
    input wire logic req_i,
    input wire logic [2:0] addr_i,
    // one station may answer corrupted
    input wire logic bad_en_i,
    input wire logic [2:0] bad_addr_i,
    output logic ok_o,
    output logic bad_o,
    output logic [15:0] data_o
);
    logic [1:0] dly = 2'h0;
    logic hit;
    initial {ok_o, bad_o, data_o} = 18'h0;
    assign hit = bad_en_i && addr_i == bad_addr_i;
    always @(posedge clk_i)
    begin
        // line toggles outside a reply so a late sample is caught
        data_o <= ~data_o;
        ok_o <= dly == 2'h1 && !hit;
        bad_o <= dly == 2'h1 && hit;
        if (dly == 2'h1)
            data_o <= {8'hA5, 5'h00, addr_i};
        dly <= req_i ? 2'h3 : dly - {1'b0, dly != 2'h0};
    end
endmodule
`default_nettype wire
